//--- hdl/caution_warning_monitor.sv
// Caution and warning monitor: fault detectors, filters and indicator drive
// Notes on behaviour
// RULE1 - No accelerometer pulse in window flags failure
// RULE2 - Simultaneous plus and minus pulses flag failure
// RULE3 - Long interval lacking both polarities flags failure
// RULE4 - Odd parity checked above octal ten
// RULE5 - Lamp test lights restart and standby
// RULE6 - Alarm reset clears restart, operator error
// RULE7 - Supply comparator excursions raise voltage failure
// RULE8 - Servo error held two seconds fails
// RULE9 - Wheel supply drop fails inertial unit
// RULE10 - Coarse align plus five seconds suppresses
// RULE11 - Five converter flags raise converter failure
// RULE12 - Zero mode suppresses inertial converter failure
// RULE13 - Temperature outside band raises indication
// RULE14 - Middle gimbal above seventy raises lock
// RULE15 - Above eighty-five: coarse align, no attitude
// RULE16 - Radar converter same flags, zero suppressed
// RULE17 - Incoherent or bad rendezvous data fails
// RULE18 - Enabled landing radar without data fails
// RULE19 - Prime supply below 23 volts fails
// RULE20 - Prime power immediate, others filtered; code filters only voltage, parity and accelerometer faults
// RULE21 - Indicators are OR of assigned flags
`timescale 1ns/100ps
`include "cw_monitor_regs.svh"
module caution_warning_monitor #(
   parameter int N_ACCEL    = 3,
   parameter int PULSE_CYC  = `PULSE_WIN_CYC,
   parameter int LONG_CYC   = `LONG_CYC,
   parameter int SERVO_CYC  = `SERVO_CYC,
   parameter int ALIGN_CYC  = `ALIGN_HOLD_CYC,
   parameter int FILT_CYC   = `FILTER_CYC
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic [31:0]        wb_adr_i,
   input  wire logic [31:0]        wb_dat_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic               wb_we_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [N_ACCEL-1:0] accel_pos_i,
   input  wire logic [N_ACCEL-1:0] accel_neg_i,
   input  wire logic               mem_read_i,
   input  wire logic [11:0]        mem_addr_i,
   input  wire logic [15:0]        mem_word_i,
   input  wire logic               lamp_test_i,
   input  wire logic               alarm_reset_i,
   input  wire logic               restart_i,
   input  wire logic               operator_error_i,
   input  wire logic               standby_i,
   input  wire logic               v4_high_i,
   input  wire logic               v4_low_i,
   input  wire logic               v28_low_i,
   input  wire logic               prime_low_i,
   input  wire logic [2:0]         servo_err_i,
   input  wire logic [1:0]         wheel_low_i,
   input  wire logic               coarse_align_req_i,
   input  wire logic [4:0]         inertial_conv_flags_i,
   input  wire logic               inertial_conv_zero_i,
   input  wire logic [4:0]         radar_conv_flags_i,
   input  wire logic               radar_conv_zero_i,
   input  wire logic [11:0]        temp_i,
   input  wire logic [11:0]        middle_gimbal_angle_i,
   input  wire logic               rr_incoherent_i,
   input  wire logic               rr_no_good_i,
   input  wire logic               lr_enabled_i,
   input  wire logic               lr_data_valid_i,
   output logic                    warning_o,
   output logic                    inertial_subsystem_warning_o,
   output logic                    restart_lamp_o,
   output logic                    standby_lamp_o,
   output logic                    operator_error_lamp_o,
   output logic                    temp_caution_o,
   output logic                    gimbal_lock_o,
   output logic                    no_attitude_lamp_o,
   output logic                    coarse_align_o,
   output logic                    radar_warning_o
);
   // Elaboration check on shapes the counters cannot serve
   if (N_ACCEL < 1 || PULSE_CYC < 1 || LONG_CYC < 1 || SERVO_CYC < 1 || ALIGN_CYC < 1 || FILT_CYC < 1) begin : g_chk
      $error("caution_warning_monitor: bad parameter");
   end

   typedef struct packed {
      logic [N_ACCEL-1:0][31:0] pulse_cnt;
      logic [N_ACCEL-1:0][31:0] long_cnt;
      logic [N_ACCEL-1:0]       seen_pos;
      logic [N_ACCEL-1:0]       seen_neg;
      logic [2:0][31:0]         servo_cnt;
      logic [31:0]              align_cnt;
      cw_monitor_pkg::align_state_t align_st;
      logic [31:0]              filt_cnt;
      logic                     accel_fail;
      logic                     parity_fail;
      logic                     restart_latch;
      logic                     opr_latch;
      logic [31:0]              ctrl;
      logic [31:0]              dat;
      logic                     ack;
      logic                     warn;
      logic                     iss_warn;
      logic                     restart_lamp;
      logic                     standby_lamp_lamp;
      logic                     opr_lamp;
      logic                     temp_c;
      logic                     glock;
      logic                     noatt;
      logic                     calign;
      logic                     rdr_warn;
      logic [15:0]              status;
   } state_t;

   state_t st;
   state_t next_st;

   logic [N_ACCEL-1:0] pulse_to;
   logic [N_ACCEL-1:0] both_pol;
   logic [N_ACCEL-1:0] long_to;
   logic [2:0]         servo_to;

   // Per-accelerometer timeout and coincidence detectors, per-gimbal timeout detectors
   genvar gi;
   for (gi = 0; gi < N_ACCEL; gi++) begin : g_accel
      assign pulse_to[gi] = (st.pulse_cnt[gi] >= 32'(PULSE_CYC - 1)) && !(accel_pos_i[gi] | accel_neg_i[gi]); // RULE1
      assign both_pol[gi] = accel_pos_i[gi] & accel_neg_i[gi]; // RULE2
      assign long_to[gi]  = (st.long_cnt[gi] >= 32'(LONG_CYC - 1)); // RULE3
   end
   for (gi = 0; gi < 3; gi++) begin : g_servo
      assign servo_to[gi] = servo_err_i[gi] && (st.servo_cnt[gi] >= 32'(SERVO_CYC - 1)); // RULE8
   end

   logic v_fail;
   logic imu_fail;
   logic iconv_fail;
   logic rconv_fail;
   logic rr_fail;
   logic lr_fail;
   logic align_supp;
   logic filtered_raw;
   logic wb_hit;

   // Combined failure terms
   always_comb begin
      v_fail       = v4_high_i | v4_low_i | v28_low_i; // RULE7
      align_supp   = (st.align_st != cw_monitor_pkg::align_idle_t) || coarse_align_req_i || st.calign; // RULE10
      imu_fail     = ((|servo_to) | (|wheel_low_i)) & ~align_supp; // RULE8 RULE9 RULE10
      iconv_fail   = (|inertial_conv_flags_i) & ~inertial_conv_zero_i; // RULE11 RULE12
      rconv_fail   = (|radar_conv_flags_i) & ~radar_conv_zero_i; // RULE16
      rr_fail      = rr_incoherent_i | rr_no_good_i; // RULE17
      lr_fail      = lr_enabled_i & ~lr_data_valid_i; // RULE18
      filtered_raw = v_fail | st.parity_fail | st.accel_fail; // RULE20
      wb_hit       = wb_cyc_i & wb_stb_i & ~st.ack;
   end

   // Next-state computation for every register of the block
   always_comb begin
      next_st = st;
      for (int i = 0; i < N_ACCEL; i++) begin
         // Short window restarts on any pulse
         if (accel_pos_i[i] | accel_neg_i[i]) begin
            next_st.pulse_cnt[i] = 32'h0000_0000;
         end else if (!pulse_to[i]) begin
            next_st.pulse_cnt[i] = st.pulse_cnt[i] + 32'h0000_0001;
         end
         // Long window restarts once both polarities have arrived
         if ((st.seen_pos[i] | accel_pos_i[i]) & (st.seen_neg[i] | accel_neg_i[i])) begin
            next_st.long_cnt[i] = 32'h0000_0000;
            next_st.seen_pos[i] = 1'b0;
            next_st.seen_neg[i] = 1'b0;
         end else begin
            next_st.seen_pos[i] = st.seen_pos[i] | accel_pos_i[i];
            next_st.seen_neg[i] = st.seen_neg[i] | accel_neg_i[i];
            if (!long_to[i]) begin
               next_st.long_cnt[i] = st.long_cnt[i] + 32'h0000_0001;
            end
         end
      end
      next_st.accel_fail = |(pulse_to | both_pol | long_to); // RULE1 RULE2 RULE3
      // Parity sampled per read so stale words do not linger as faults
      next_st.parity_fail = mem_read_i && (mem_addr_i > `PARITY_MIN_ADDR) && !(^mem_word_i); // RULE4
      for (int g = 0; g < 3; g++) begin
         next_st.servo_cnt[g] = servo_err_i[g] ? (servo_to[g] ? st.servo_cnt[g] : st.servo_cnt[g] + 32'h0000_0001)
                                               : 32'h0000_0000; // RULE8
      end
      // Coarse align tracker with hold-off after it ends
      case (st.align_st)
         cw_monitor_pkg::align_idle_t: begin
            if (coarse_align_req_i || st.calign) begin
               next_st.align_st = cw_monitor_pkg::align_on_t;
            end
         end
         cw_monitor_pkg::align_on_t: begin
            next_st.align_cnt = 32'h0000_0000;
            if (!(coarse_align_req_i || st.calign)) begin
               next_st.align_st = cw_monitor_pkg::align_hold_t;
            end
         end
         cw_monitor_pkg::align_hold_t: begin
            if (coarse_align_req_i || st.calign) begin
               next_st.align_st = cw_monitor_pkg::align_on_t;
            end else if (st.align_cnt >= 32'(ALIGN_CYC - 1)) begin
               next_st.align_st = cw_monitor_pkg::align_idle_t; // RULE10
            end else begin
               next_st.align_cnt = st.align_cnt + 32'h0000_0001;
            end
         end
         default: next_st.align_st = cw_monitor_pkg::align_idle_t;
      endcase
      // Filter: a fault must persist before it becomes a warning
      if (filtered_raw) begin
         if (st.filt_cnt < 32'(FILT_CYC)) begin
            next_st.filt_cnt = st.filt_cnt + 32'h0000_0001;
         end
      end else begin
         next_st.filt_cnt = 32'h0000_0000;
      end
      // Latched lamps: set wins over alarm reset
      next_st.restart_latch = restart_i | (st.restart_latch & ~alarm_reset_i); // RULE6
      next_st.opr_latch     = operator_error_i | (st.opr_latch & ~alarm_reset_i); // RULE6
      // Indicator outputs
      next_st.warn = prime_low_i | (st.filt_cnt >= 32'(FILT_CYC)) | (st.ctrl[0] & filtered_raw); // RULE19 RULE20 RULE21
      next_st.iss_warn     = imu_fail | iconv_fail; // RULE10 RULE12 RULE21
      next_st.restart_lamp = st.restart_latch | lamp_test_i; // RULE5
      next_st.standby_lamp_lamp    = standby_i | lamp_test_i; // RULE5
      next_st.opr_lamp     = st.opr_latch;
      next_st.temp_c       = (temp_i < `TEMP_LOW) || (temp_i > `TEMP_HIGH); // RULE13
      next_st.glock        = middle_gimbal_angle_i > `ANGLE_LOCK; // RULE14
      next_st.noatt        = middle_gimbal_angle_i > `ANGLE_NO_ATTITUDE_LAMP; // RULE15
      next_st.calign       = middle_gimbal_angle_i > `ANGLE_NO_ATTITUDE_LAMP; // RULE15
      next_st.rdr_warn     = rconv_fail | rr_fail | lr_fail; // RULE16 RULE17 RULE18 RULE21
      next_st.status = {5'h00, prime_low_i, lr_fail, rr_fail, rconv_fail, iconv_fail, imu_fail, v_fail,
                        st.parity_fail, st.accel_fail, st.restart_latch, st.opr_latch};
      // Wishbone slave: one-cycle answer, ack dropped the cycle after
      next_st.ack = wb_hit;
      next_st.dat = 32'h0000_0000;
      if (wb_hit) begin
         if (wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0]) begin
            next_st.ctrl = {31'h0000_0000, wb_dat_i[0]};
         end
         if (!wb_we_i) begin
            if (wb_adr_i == `REG_CTRL) begin
               next_st.dat = st.ctrl;
            end else if (wb_adr_i == `REG_STATUS) begin
               next_st.dat = {16'h0000, st.status};
            end
         end
      end
   end

   // Single state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st          <= '0;
         st.align_st <= cw_monitor_pkg::align_idle_t;
         st.ctrl     <= `REG_CTRL_DEFAULT;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign wb_dat_o                     = st.dat;
   assign wb_ack_o                     = st.ack;
   assign warning_o                    = st.warn;
   assign inertial_subsystem_warning_o = st.iss_warn;
   assign restart_lamp_o               = st.restart_lamp;
   assign standby_lamp_o               = st.standby_lamp_lamp;
   assign operator_error_lamp_o        = st.opr_lamp;
   assign temp_caution_o               = st.temp_c;
   assign gimbal_lock_o                = st.glock;
   assign no_attitude_lamp_o           = st.noatt;
   assign coarse_align_o               = st.calign;
   assign radar_warning_o              = st.rdr_warn;
endmodule

//--- include/cw_monitor_regs.svh
// Constants for the caution and warning monitor
`ifndef CW_MONITOR_REGS_SVH
`define CW_MONITOR_REGS_SVH
`define CLK_PERIOD_NS       100
`define PULSE_WINDOW_NS     312500
`define PULSE_WIN_CYC       ((`PULSE_WINDOW_NS * 10 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_MIN_MS         1280
`define LONG_MAX_MS         3840
`define LONG_CYC            (`LONG_MIN_MS * 100000)
`define SERVO_TIME_MS       2000
`define SERVO_CYC           (`SERVO_TIME_MS * 100000)
`define ALIGN_HOLD_MS       5000
`define ALIGN_HOLD_CYC      (`ALIGN_HOLD_MS * 100000)
`define FILTER_CYC          16
`define PARITY_MIN_ADDR     12'h008
`define TEMP_LOW            12'h4EF
`define TEMP_HIGH           12'h53F
`define ANGLE_LOCK          12'h2BC
`define ANGLE_NO_ATTITUDE_LAMP        12'h352
`define REG_CTRL            32'h0000_0000
`define REG_STATUS          32'h0000_0004
`define REG_CTRL_DEFAULT    32'h0000_0000
`endif

//--- include/cw_monitor_pkg.sv
// Types shared by the caution and warning monitor
package cw_monitor_pkg;
   typedef enum logic [2:0] {
      align_idle_t = 3'h1,
      align_on_t   = 3'h2,
      align_hold_t = 3'h4
   } align_state_t;
endpackage

//--- tb/caution_warning_monitor_props.sv
// Port-level checker for the caution and warning monitor
`timescale 1ns/100ps
module caution_warning_monitor_props (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        lamp_test_i,
   input wire logic        alarm_reset_i,
   input wire logic        restart_i,
   input wire logic        operator_error_i,
   input wire logic        v4_high_i,
   input wire logic        prime_low_i,
   input wire logic [11:0] temp_i,
   input wire logic [11:0] middle_gimbal_angle_i,
   input wire logic        warning_o,
   input wire logic        restart_lamp_o,
   input wire logic        standby_lamp_o,
   input wire logic        operator_error_lamp_o,
   input wire logic        temp_caution_o,
   input wire logic        gimbal_lock_o,
   input wire logic        no_attitude_lamp_o,
   input wire logic        coarse_align_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Eight cycles of a held excursion; two of them plus four outlast the warning filter
   sequence s_v_hold8;
      v4_high_i [*8];
   endsequence
   AST_LAMP_TEST: assert property (lamp_test_i |=> restart_lamp_o && standby_lamp_o)
      else $error("lamp test did not light restart and standby");
   // Latched lamps clear one edge after the latch, so the lamp drops two cycles after reset is sampled
   AST_RESET_RESTART: assert property (alarm_reset_i && !restart_i ##1 !lamp_test_i |=> !restart_lamp_o)
      else $error("alarm reset left restart lamp lit");
   AST_RESET_OPR: assert property (alarm_reset_i && !operator_error_i |=> ##1 !operator_error_lamp_o)
      else $error("alarm reset left operator error lamp lit");
   AST_TEMP_OUT: assert property (temp_i < 12'h4EF || temp_i > 12'h53F |=> temp_caution_o)
      else $error("temperature outside band not flagged");
   AST_TEMP_IN: assert property (temp_i >= 12'h4EF && temp_i <= 12'h53F |=> !temp_caution_o)
      else $error("temperature inside band flagged");
   AST_LOCK_ON: assert property (middle_gimbal_angle_i > 12'h2BC |=> gimbal_lock_o)
      else $error("gimbal lock missing above limit");
   AST_LOCK_OFF: assert property (middle_gimbal_angle_i <= 12'h2BC |=> !gimbal_lock_o)
      else $error("gimbal lock raised below limit");
   AST_NO_ATTITUDE_LAMP: assert property (middle_gimbal_angle_i > 12'h352 |=> no_attitude_lamp_o && coarse_align_o)
      else $error("no attitude or coarse align missing");
   AST_PRIME: assert property (prime_low_i |=> warning_o)
      else $error("prime power failure did not warn at once");
   AST_FILTER: assert property (s_v_hold8 ##1 s_v_hold8 ##1 v4_high_i [*4] |=> warning_o)
      else $error("held voltage failure did not warn");
endmodule
bind caution_warning_monitor caution_warning_monitor_props u_props (.clk_i, .rst_i, .lamp_test_i, .alarm_reset_i,
   .restart_i, .operator_error_i, .v4_high_i, .prime_low_i, .temp_i, .middle_gimbal_angle_i, .warning_o,
   .restart_lamp_o, .standby_lamp_o, .operator_error_lamp_o, .temp_caution_o, .gimbal_lock_o, .no_attitude_lamp_o,
   .coarse_align_o);

//--- tb/cw_accel_source.sv
// Accelerometer pulse source standing in for the inertial unit
`timescale 1ns/100ps
module cw_accel_source #(
   parameter int N_ACCEL = 3,
   parameter int PERIOD  = 10
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic [1:0]         mode_i,
   output logic      [N_ACCEL-1:0] pos_o,
   output logic      [N_ACCEL-1:0] neg_o
);
   int   cnt;
   logic sign;
   // Mode 0 alternates polarity, 1 is silent, 2 fires both every cycle, 3 is positive only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 0;
         sign <= 1'b0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         sign <= (cnt == PERIOD - 1) ? ~sign : sign;
      end
   end
   assign pos_o = {N_ACCEL{mode_i == 2'h2 || (cnt == 0 && mode_i != 2'h1 && (!sign || mode_i == 2'h3))}};
   assign neg_o = {N_ACCEL{mode_i == 2'h2 || (cnt == 0 && mode_i == 2'h0 && sign)}};
endmodule

//--- tb/caution_warning_monitor_tb.sv
// Self-checking testbench for the caution and warning monitor
`timescale 1ns/100ps
`include "cw_monitor_regs.svh"
module caution_warning_monitor_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [31:0] wb_adr_i = '0;
   logic [31:0] wb_dat_i = '0;
   logic [3:0]  wb_sel_i = '0;
   logic        wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [2:0]  accel_pos_i;
   logic [2:0]  accel_neg_i;
   logic [1:0]  mode = '0;
   logic        mem_read_i = 1'b0;
   logic [11:0] mem_addr_i = '0;
   logic [15:0] mem_word_i = '0;
   logic        lamp_test_i = 1'b0, alarm_reset_i = 1'b0, restart_i = 1'b0, operator_error_i = 1'b0;
   logic        standby_i = 1'b0, coarse_align_req_i = 1'b0, lr_enabled_i = 1'b0, lr_data_valid_i = 1'b0;
   logic        inertial_conv_zero_i = 1'b0, radar_conv_zero_i = 1'b0;
   logic [20:0] lv = '0;
   logic [11:0] temp_i = 12'h514;
   logic [11:0] middle_gimbal_angle_i = '0;
   logic [9:0]  lamp;
   int          n_mismatch = 0;
   int          comparisons = 0;
   // Fault levels in lv: supplies 0-3, servo 4-6, wheels 7-8, converters 9-18, rendezvous radar 19-20
   caution_warning_monitor #(.PULSE_CYC(50), .LONG_CYC(200), .SERVO_CYC(100), .ALIGN_CYC(100)) u_dut (
      .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_dat_o,
      .wb_ack_o, .accel_pos_i, .accel_neg_i, .mem_read_i, .mem_addr_i, .mem_word_i, .lamp_test_i, .alarm_reset_i,
      .restart_i, .operator_error_i, .standby_i, .v4_high_i(lv[0]), .v4_low_i(lv[1]), .v28_low_i(lv[2]),
      .prime_low_i(lv[3]), .servo_err_i(lv[6:4]), .wheel_low_i(lv[8:7]), .coarse_align_req_i,
      .inertial_conv_flags_i(lv[13:9]), .inertial_conv_zero_i, .radar_conv_flags_i(lv[18:14]), .radar_conv_zero_i,
      .temp_i, .middle_gimbal_angle_i, .rr_incoherent_i(lv[19]), .rr_no_good_i(lv[20]), .lr_enabled_i,
      .lr_data_valid_i, .warning_o(lamp[0]), .inertial_subsystem_warning_o(lamp[1]), .restart_lamp_o(lamp[2]),
      .standby_lamp_o(lamp[3]), .operator_error_lamp_o(lamp[4]), .temp_caution_o(lamp[5]), .gimbal_lock_o(lamp[6]),
      .no_attitude_lamp_o(lamp[7]), .coarse_align_o(lamp[8]), .radar_warning_o(lamp[9]));
   cw_accel_source u_src (.clk_i, .rst_i, .mode_i(mode), .pos_o(accel_pos_i), .neg_o(accel_neg_i));
   always #5 clk_i = ~clk_i;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, release there, idle one cycle before the next
   task automatic wb(input logic [31:0] a, input logic w, input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 50) chk(1'b0, 1'b1);
   endtask
   task automatic st(input int b, input logic e);
      logic [31:0] q;
      wb(`REG_STATUS, 1'b0, 4'hF, 32'h0, q);
      chk(q[b], e);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      wb(`REG_STATUS, 1'b1, 4'hF, 32'hFFF, q);
      wb(32'h10, 1'b1, 4'hF, 32'h1, q);
      wb(32'h10, 1'b0, 4'hF, 32'h0, q);
      chk(q, 32'h0);
      wb(`REG_STATUS, 1'b0, 4'hF, 32'h0, q);
      chk(q, 32'h0);
      lv[0] <= 1'b1;
      cyc(3);
      lv[0] <= 1'b0;
      repeat (6) begin
         cyc(1);
         chk(lamp[0], 1'b0);
      end
      wb(`REG_CTRL, 1'b1, 4'hE, 32'h1, q);
      wb(`REG_CTRL, 1'b0, 4'hF, 32'h0, q);
      chk(q, `REG_CTRL_DEFAULT);
      wb(`REG_CTRL, 1'b1, 4'h1, 32'h1, q);
      lv[0] <= 1'b1;
      cyc(3);
      chk(lamp[0], 1'b1);
      lv[0] <= 1'b0;
      wb(`REG_CTRL, 1'b1, 4'hF, 32'h0, q);
   endtask
   // Silence, both polarities at once, then a positive-only stretch longer than the long window
   task automatic t_accel();
      mode <= 2'h1;
      cyc(80);
      st(2, 1'b1);
      mode <= 2'h2;
      cyc(30);
      st(2, 1'b1);
      mode <= 2'h3;
      cyc(300);
      st(2, 1'b1);
      mode <= 2'h0;
      cyc(60);
      st(2, 1'b0);
   endtask
   // Parity flag lives one cycle only, so it is watched through the filter bypass on the warning
   task automatic t_parity(input logic [11:0] a, input logic [15:0] w, input logic e);
      logic [31:0] q;
      wb(`REG_CTRL, 1'b1, 4'h1, 32'h1, q);
      mem_addr_i <= a;
      mem_word_i <= w;
      mem_read_i <= 1'b1;
      cyc(1);
      mem_read_i <= 1'b0;
      cyc(2);
      chk(lamp[0], e);
      wb(`REG_CTRL, 1'b1, 4'hF, 32'h0, q);
   endtask
   task automatic t_lamps();
      lamp_test_i <= 1'b1;
      cyc(2);
      chk(lamp[3:2], 2'h3);
      lamp_test_i <= 1'b0;
      restart_i <= 1'b1;
      operator_error_i <= 1'b1;
      cyc(1);
      restart_i <= 1'b0;
      operator_error_i <= 1'b0;
      cyc(3);
      chk({lamp[4], lamp[2]}, 2'h3);
      alarm_reset_i <= 1'b1;
      cyc(2);
      alarm_reset_i <= 1'b0;
      cyc(1);
      chk({lamp[4], lamp[2]}, 2'h0);
      for (int i = 0; i < 4; i++) begin
         temp_i <= i[0] ? 12'h53E + i[1] : 12'h4EE + i[1];
         middle_gimbal_angle_i <= i[0] ? 12'h352 + i[1] : 12'h2BC + i[1];
         cyc(2);
         chk(lamp[5], temp_i < 12'h4EF || temp_i > 12'h53F);
         chk(lamp[8:6], {{2{middle_gimbal_angle_i > 12'h352}}, middle_gimbal_angle_i > 12'h2BC});
      end
      middle_gimbal_angle_i <= '0;
   endtask
   // Suppressed and short-lived causes first, as some status flags may latch
   task automatic t_suppress();
      inertial_conv_zero_i <= 1'b1;
      radar_conv_zero_i <= 1'b1;
      lv[18:9] <= '1;
      cyc(5);
      st(6, 1'b0);
      st(7, 1'b0);
      lv[18:9] <= '0;
      inertial_conv_zero_i <= 1'b0;
      radar_conv_zero_i <= 1'b0;
      lv[4] <= 1'b1;
      cyc(50);
      st(5, 1'b0);
      lv[4] <= 1'b0;
      lr_enabled_i <= 1'b1;
      lr_data_valid_i <= 1'b1;
      cyc(3);
      st(9, 1'b0);
      lr_data_valid_i <= 1'b0;
      cyc(3);
      st(9, 1'b1);
      coarse_align_req_i <= 1'b1;
      lv[7] <= 1'b1;
      cyc(20);
      st(5, 1'b0);
      chk(lamp[1], 1'b0);
      coarse_align_req_i <= 1'b0;
      cyc(50);
      st(5, 1'b0);
      cyc(80);
      st(5, 1'b1);
      lv[7] <= 1'b0;
   endtask
   task automatic t_table();
      for (int k = 0; k < 21; k++) begin
         lv[k] <= 1'b1;
         cyc(120);
         st(k < 3 ? 4 : k == 3 ? 10 : k < 9 ? 5 : k < 14 ? 6 : k < 19 ? 7 : 8, 1'b1);
         lv[k] <= 1'b0;
         cyc(5);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Whole run is near 3500 cycles; the watchdog allows about 28 times that
   initial begin
      #1000000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_accel();
      t_parity(12'h009, 16'h0001, 1'b0);
      t_parity(12'h008, 16'h0000, 1'b0);
      t_parity(12'h009, 16'h0003, 1'b1);
      t_lamps();
      t_suppress();
      t_table();
      finish_test();
   end
endmodule
